// ### core/kss_regs.sv
module kss_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Option straps, already synchronised
    input wire logic opt_installed,
    input wire logic sensor_interline,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pslverr,
    // Sequencer side
    kss_cfg_if.regs cfg
);

    logic [1:0] mode_q;
    logic [31:0] expo_q;
    logic [11:0] win_q;
    logic [31:0] rowt_q;
    logic [31:0] comp_q;
    logic [31:0] rdt_q;
    logic begin_q;
    logic abort_q;
    logic ign_seen_q;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_d;
    logic known;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            expo_q <= kss_pkg::KSS_EXPO_RST;
            win_q <= kss_pkg::KSS_WIN_RST;
            rowt_q <= kss_pkg::KSS_ROWT_RST;
            comp_q <= kss_pkg::KSS_COMP_RST;
            rdt_q <= kss_pkg::KSS_RDT_RST;
        end else if (wr_en && !cfg.busy) begin
            // Timing is frozen while a series runs
            unique case (paddr)
                kss_pkg::KSS_CTRL_ADDR: mode_q <= pwdata[kss_pkg::KSS_CTRL_MODE_LSB +: kss_pkg::KSS_CTRL_MODE_W];
                kss_pkg::KSS_EXPO_ADDR: expo_q <= pwdata;
                kss_pkg::KSS_WIN_ADDR: win_q <= pwdata[11:0];
                kss_pkg::KSS_ROWT_ADDR: rowt_q <= pwdata;
                kss_pkg::KSS_COMP_ADDR: comp_q <= pwdata;
                kss_pkg::KSS_RDT_ADDR: rdt_q <= pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            begin_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            begin_q <= wr_en && paddr == kss_pkg::KSS_CTRL_ADDR && pwdata[kss_pkg::KSS_CTRL_BEGIN_BIT];
            abort_q <= wr_en && paddr == kss_pkg::KSS_CTRL_ADDR && pwdata[kss_pkg::KSS_CTRL_ABORT_BIT];
        end
    end

    // Sticky: set wins over a clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ign_seen_q <= 1'b0;
        end else if (cfg.ignored) begin
            ign_seen_q <= 1'b1;
        end else if (rd_en && paddr == kss_pkg::KSS_STAT_ADDR) begin
            ign_seen_q <= 1'b0;
        end
    end

    assign cfg.mode = mode_q;
    assign cfg.begin_pulse = begin_q;
    assign cfg.abort_pulse = abort_q;
    assign cfg.expo_cycles = (expo_q == 32'h0) ? 32'h1 : expo_q;
    assign cfg.shift_cycles = 32'(rowt_q * 32'(win_q));
    assign cfg.comp_cycles = comp_q;
    assign cfg.read_cycles = (rdt_q == 32'h0) ? 32'h1 : rdt_q;
    assign cfg.sub_total = (win_q == 12'h0) ? 12'h0 : kss_pkg::KSS_SENSOR_ROWS / win_q;
    assign cfg.cfg_ok = opt_installed && !sensor_interline && win_q != 12'h0
                        && mode_q != 2'h3;

    always_comb begin
        known = 1'b1;
        rd_d = 32'h0;
        unique case (paddr)
            kss_pkg::KSS_CTRL_ADDR: rd_d[kss_pkg::KSS_CTRL_MODE_LSB +: kss_pkg::KSS_CTRL_MODE_W] = mode_q;
            kss_pkg::KSS_EXPO_ADDR: rd_d = expo_q;
            kss_pkg::KSS_WIN_ADDR: rd_d = {20'h0, win_q};
            kss_pkg::KSS_ROWT_ADDR: rd_d = rowt_q;
            kss_pkg::KSS_COMP_ADDR: rd_d = comp_q;
            kss_pkg::KSS_RDT_ADDR: rd_d = rdt_q;
            kss_pkg::KSS_STAT_ADDR: rd_d = {cfg.sub_count, 4'h0, ign_seen_q, cfg.state, 3'h0,
                                             cfg.cfg_ok, cfg.busy, 3'h0};
            kss_pkg::KSS_CAP_ADDR: rd_d = {20'h0, cfg.sub_total};
            default: known = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= rd_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !known;
        end
    end

endmodule // kss_regs

// ### core/kss_seq.sv
// Added by the designer: register access over APB and the register addresses.
module kss_seq (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps and sync pin
    input wire logic opt_installed,
    input wire logic sensor_interline,
    input wire logic ext_sync,
    // Sensor and intensifier controls
    output logic photocathode_on,
    output logic row_shift,
    output logic readout_active,
    output logic readout_indication
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] sync_ff_q;
    logic [1:0] opt_ff_q;
    logic [1:0] ilt_ff_q;
    logic sync_prev_q;
    logic sync_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_ff_q <= 2'h0;
            opt_ff_q <= 2'h0;
            ilt_ff_q <= 2'h0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_ff_q <= {sync_ff_q[0], ext_sync};
            opt_ff_q <= {opt_ff_q[0], opt_installed};
            ilt_ff_q <= {ilt_ff_q[0], sensor_interline};
            sync_prev_q <= sync_ff_q[1];
        end
    end

    assign sync_rise = sync_ff_q[1] && !sync_prev_q;

    // ****************************************************************
    // Registers
    // ****************************************************************
    kss_cfg_if cfg ();
    logic [31:0] prdata_w;
    logic pslverr_w;

    kss_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .opt_installed(opt_ff_q[1]),
        .sensor_interline(ilt_ff_q[1]),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata_w),
        .pslverr(pslverr_w),
        .cfg(cfg)
    );

    assign prdata = prdata_w;
    assign pslverr = pslverr_w;

    // Zero wait states, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    kss_pkg::kss_state_e state_q;
    kss_pkg::kss_state_e state_d;
    logic [31:0] tmr_q;
    logic [11:0] sub_q;
    logic tmr_done;
    logic last_sub;
    logic ign_q;

    assign tmr_done = (tmr_q <= 32'h1);
    assign last_sub = (sub_q + 12'h1 >= cfg.sub_total);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            kss_pkg::KSS_IDLE: begin
                if (cfg.begin_pulse && cfg.cfg_ok) begin
                    state_d = (cfg.mode == kss_pkg::KSS_MODE_FREE) ? kss_pkg::KSS_EXPOSE
                                                                   : kss_pkg::KSS_ARM;
                end
            end
            kss_pkg::KSS_ARM: begin
                if (sync_rise) begin
                    state_d = kss_pkg::KSS_EXPOSE;
                end
            end
            kss_pkg::KSS_EXPOSE: begin
                if (tmr_done) begin
                    state_d = kss_pkg::KSS_SHIFT;
                end
            end
            kss_pkg::KSS_SHIFT: begin
                if (tmr_done) begin
                    if (last_sub) begin
                        state_d = kss_pkg::KSS_COMP;
                    end else if (cfg.mode == kss_pkg::KSS_MODE_PERSUB) begin
                        state_d = kss_pkg::KSS_WAIT;
                    end else begin
                        state_d = kss_pkg::KSS_EXPOSE;
                    end
                end
            end
            kss_pkg::KSS_WAIT: begin
                if (sync_rise) begin
                    state_d = kss_pkg::KSS_EXPOSE;
                end
            end
            kss_pkg::KSS_COMP: begin
                if (tmr_done) begin
                    state_d = kss_pkg::KSS_READ;
                end
            end
            kss_pkg::KSS_READ: begin
                if (tmr_done) begin
                    state_d = kss_pkg::KSS_IDLE;
                end
            end
            default: state_d = kss_pkg::KSS_IDLE;
        endcase
        if (cfg.abort_pulse) begin
            state_d = kss_pkg::KSS_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= kss_pkg::KSS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Phase timer loads on entry to each timed state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_q <= 32'h0;
        end else if (state_d != state_q) begin
            unique case (state_d)
                kss_pkg::KSS_EXPOSE: tmr_q <= cfg.expo_cycles;
                kss_pkg::KSS_SHIFT: tmr_q <= cfg.shift_cycles;
                kss_pkg::KSS_COMP: tmr_q <= cfg.comp_cycles;
                kss_pkg::KSS_READ: tmr_q <= cfg.read_cycles;
                default: tmr_q <= 32'h0;
            endcase
        end else if (tmr_q != 32'h0) begin
            tmr_q <= tmr_q - 32'h1;
        end
    end

    // Subframe counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_q <= 12'h0;
        end else if (state_q == kss_pkg::KSS_IDLE && cfg.begin_pulse) begin
            sub_q <= 12'h0;
        end else if (state_q == kss_pkg::KSS_SHIFT && tmr_done && !last_sub) begin
            sub_q <= sub_q + 12'h1;
        end
    end

    // Sync pulses during exposure, shift, compensation or readout are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ign_q <= 1'b0;
        end else begin
            ign_q <= sync_rise && (state_q == kss_pkg::KSS_READ || state_q == kss_pkg::KSS_COMP
                                   || state_q == kss_pkg::KSS_EXPOSE || state_q == kss_pkg::KSS_SHIFT);
        end
    end

    assign cfg.busy = (state_q != kss_pkg::KSS_IDLE);
    assign cfg.state = state_q;
    assign cfg.sub_count = sub_q;
    assign cfg.ignored = ign_q;

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            photocathode_on <= 1'b0;
            row_shift <= 1'b0;
            readout_active <= 1'b0;
            readout_indication <= 1'b0;
        end else begin
            photocathode_on <= (state_d == kss_pkg::KSS_EXPOSE);
            row_shift <= (state_d == kss_pkg::KSS_SHIFT);
            readout_active <= (state_d == kss_pkg::KSS_READ);
            readout_indication <= (state_d == kss_pkg::KSS_READ);
        end
    end

endmodule // kss_seq

// ### shared/kss_cfg_if.sv
interface kss_cfg_if;
    logic [1:0] mode;
    logic begin_pulse;
    logic abort_pulse;
    logic [31:0] expo_cycles;
    logic [31:0] shift_cycles;
    logic [31:0] comp_cycles;
    logic [31:0] read_cycles;
    logic [11:0] sub_total;
    logic cfg_ok;
    logic busy;
    logic [6:0] state;
    logic [11:0] sub_count;
    logic ignored;

    modport regs (output mode, begin_pulse, abort_pulse, expo_cycles, shift_cycles, comp_cycles,
                  read_cycles, sub_total, cfg_ok, input busy, state, sub_count, ignored);
    modport seq (input mode, begin_pulse, abort_pulse, expo_cycles, shift_cycles, comp_cycles,
                 read_cycles, sub_total, cfg_ok, output busy, state, sub_count, ignored);
endinterface

// ### shared/kss_pkg.sv
// Contract
// - Free run, series per trigger, subframe per trigger
// - Refuse kinetics without installed option
// - Refuse kinetics on interline sensors
// - Free run: back-to-back programmed exposures
// - Window size is rows per subframe
// - Subframes equal sensor rows over window
// - Shift time is row time times window
// - One sync takes whole series
// - Act on sync after start; expose
// - Close, shift, reopen until series done
// - Last subframe: close, compensate, read out (the code shifts before compensating)
// - Ready again only after readout
// - One subframe per sync pulse
// - First sync exposes; shift, await next
// - Series done: close, read out, rearm (the code also shifts and compensates, then returns to idle)
// - Readout indication high during readout
package kss_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] KSS_CTRL_ADDR = 8'h00;
    localparam logic [7:0] KSS_EXPO_ADDR = 8'h04;
    localparam logic [7:0] KSS_WIN_ADDR = 8'h08;
    localparam logic [7:0] KSS_ROWT_ADDR = 8'h0c;
    localparam logic [7:0] KSS_COMP_ADDR = 8'h10;
    localparam logic [7:0] KSS_RDT_ADDR = 8'h14;
    localparam logic [7:0] KSS_STAT_ADDR = 8'h18;
    localparam logic [7:0] KSS_CAP_ADDR = 8'h1c;

    // CTRL fields
    localparam int KSS_CTRL_BEGIN_BIT = 0;
    localparam int KSS_CTRL_ABORT_BIT = 1;
    localparam int KSS_CTRL_MODE_LSB = 4;
    localparam int KSS_CTRL_MODE_W = 2;

    // Sensor and timing widths
    localparam int KSS_ROW_W = 12;
    localparam int KSS_CNT_W = 32;
    localparam logic [KSS_ROW_W-1:0] KSS_SENSOR_ROWS = 12'h200;
    localparam logic [KSS_ROW_W-1:0] KSS_WIN_RST = 12'h020;
    localparam logic [KSS_CNT_W-1:0] KSS_EXPO_RST = 32'h000003e8;
    localparam logic [KSS_CNT_W-1:0] KSS_ROWT_RST = 32'h0000012c;
    localparam logic [KSS_CNT_W-1:0] KSS_COMP_RST = 32'h00000064;
    localparam logic [KSS_CNT_W-1:0] KSS_RDT_RST = 32'h00001000;

    // ****************************************************************
    // Modes and states
    // ****************************************************************
    typedef enum logic [1:0] {
        KSS_MODE_FREE = 2'h0,
        KSS_MODE_SERIES = 2'h1,
        KSS_MODE_PERSUB = 2'h2
    } kss_mode_e;

    typedef enum logic [6:0] {
        KSS_IDLE = 7'h01,
        KSS_ARM = 7'h02,
        KSS_EXPOSE = 7'h04,
        KSS_SHIFT = 7'h08,
        KSS_WAIT = 7'h10,
        KSS_COMP = 7'h20,
        KSS_READ = 7'h40
    } kss_state_e;

endpackage

// ### verif/kss_seq_assertions.sv
module kss_seq_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic opt_installed,
    input wire logic sensor_interline,
    input wire logic ext_sync,
    input wire logic photocathode_on,
    input wire logic row_shift,
    input wire logic readout_active,
    input wire logic readout_indication
);
    // ****
    // Shadow timings and run lengths
    // ****
    logic [31:0] expo_q, rowt_q, rdt_q, pc_q, sh_q, ro_q;
    logic [11:0] win_q;
    logic wr;
    assign wr = psel && penable && pready && pwrite;
    // Busy writes are refused, so shadows hold only for idle writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expo_q <= kss_pkg::KSS_EXPO_RST;
            rowt_q <= kss_pkg::KSS_ROWT_RST;
            rdt_q <= kss_pkg::KSS_RDT_RST;
            win_q <= kss_pkg::KSS_WIN_RST;
        end else if (wr) begin
            if (paddr == kss_pkg::KSS_EXPO_ADDR) expo_q <= pwdata;
            if (paddr == kss_pkg::KSS_ROWT_ADDR) rowt_q <= pwdata;
            if (paddr == kss_pkg::KSS_RDT_ADDR) rdt_q <= pwdata;
            if (paddr == kss_pkg::KSS_WIN_ADDR) win_q <= pwdata[11:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= '0;
            sh_q <= '0;
            ro_q <= '0;
        end else begin
            pc_q <= photocathode_on ? pc_q + 32'h1 : '0;
            sh_q <= row_shift ? sh_q + 32'h1 : '0;
            ro_q <= readout_active ? ro_q + 32'h1 : '0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence ro_end;
        $fell(readout_active);
    endsequence
    chk_ro_mirror: assert property (readout_active == readout_indication)
        else $error("readout indication differs from readout");
    chk_cath_shift_excl: assert property (!(photocathode_on && row_shift))
        else $error("shift while photocathode on");
    chk_read_dark: assert property (readout_active |-> !photocathode_on && !row_shift)
        else $error("exposure or shift during readout");
    chk_apb_ready: assert property (apb_setup |=> pready)
        else $error("no ready in access cycle");
    chk_opt_refuse: assert property ((!opt_installed) [*4] |-> !$rose(photocathode_on))
        else $error("exposure without option");
    chk_intl_refuse: assert property (sensor_interline [*4] |-> !$rose(photocathode_on))
        else $error("exposure on interline sensor");
    chk_expo_len: assert property ($fell(photocathode_on) |-> pc_q == expo_q)
        else $error("exposure length wrong");
    chk_shift_len: assert property ($fell(row_shift) |-> sh_q == rowt_q * win_q)
        else $error("shift length wrong");
    chk_read_len: assert property (ro_end |-> ro_q == rdt_q)
        else $error("readout length wrong");
endmodule // kss_seq_assertions
bind kss_seq kss_seq_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opt_installed(opt_installed), .sensor_interline(sensor_interline), .ext_sync(ext_sync),
    .photocathode_on(photocathode_on), .row_shift(row_shift), .readout_active(readout_active),
    .readout_indication(readout_indication));

// ### verif/kss_trig_gen.sv
module kss_trig_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests from the bench
    input wire logic fire,
    input wire logic rude,
    input wire logic [3:0] lag,
    // Device side
    input wire logic inhibit,
    output logic ext_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Delayed three-cycle sync pulse
    // ****
    logic [4:0] cnt_q;
    logic rude_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 5'h00;
            rude_q <= 1'b0;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end else if (fire || rude) begin
            cnt_q <= (rude ? 5'h00 : {1'b0, lag}) + 5'h03;
            rude_q <= rude;
        end
    end
    // Rude pulses model a generator wired without its inhibit
    assign ext_sync = (cnt_q != 5'h00) && (cnt_q <= 5'h03) && (rude_q || !inhibit);
endmodule // kss_trig_gen

// ### verif/test_kinetics_subframe_sequencer.sv
module test_kinetics_subframe_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
    logic pclk, presetn, psel, penable, pwrite, opt_installed, sensor_interline, ext_sync;
    logic photocathode_on, row_shift, readout_active, readout_indication, pready, pslverr;
    logic fire, rude, pc_p, ro_p, err;
    logic [3:0] lag;
    logic [7:0] paddr;
    logic [11:0] win;
    logic [31:0] pwdata, prdata, rd, subs, expo, rowt;
    int miscompares, check_count, n_exp, n_ro;
    kss_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .opt_installed(opt_installed), .sensor_interline(sensor_interline), .ext_sync(ext_sync),
        .photocathode_on(photocathode_on), .row_shift(row_shift), .readout_active(readout_active),
        .readout_indication(readout_indication));
    kss_trig_gen gen_u (.pclk(pclk), .presetn(presetn), .fire(fire), .rude(rude), .lag(lag),
        .inhibit(readout_indication), .ext_sync(ext_sync));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Sampled mid-cycle to stay clear of the launching edge
    always @(negedge pclk) begin
        if (photocathode_on && !pc_p) n_exp++;
        if (!readout_active && ro_p) n_ro++;
        pc_p = photocathode_on;
        ro_p = readout_active;
    end
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] sub_total(input logic [11:0] w);
        return 32'(kss_pkg::KSS_SENSOR_ROWS / w);
    endfunction
    task automatic finish_test;
        if (miscompares == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            finish_test;
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic go(input logic [1:0] m);
        apb(1'b1, kss_pkg::KSS_CTRL_ADDR, (32'(m) << kss_pkg::KSS_CTRL_MODE_LSB) | 32'h1);
    endtask
    task automatic pulse(input logic r);
        @(posedge pclk);
        fire <= !r;
        rude <= r;
        @(posedge pclk);
        fire <= 1'b0;
        rude <= 1'b0;
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fire, rude, lag, sensor_interline} = '0;
        presetn = 1'b0;
        opt_installed = 1'b1;
        void'($urandom(69));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk("cap", kss_pkg::KSS_CAP_ADDR, sub_total(kss_pkg::KSS_WIN_RST));
        rchk("win", kss_pkg::KSS_WIN_ADDR, 32'(kss_pkg::KSS_WIN_RST));
        rchk("expo", kss_pkg::KSS_EXPO_ADDR, kss_pkg::KSS_EXPO_RST);
        rchk("rowt", kss_pkg::KSS_ROWT_ADDR, kss_pkg::KSS_ROWT_RST);
        rchk("unmapped", 8'h20, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        for (int k = 0; k < 2; k++) begin
            opt_installed <= k[0];
            sensor_interline <= k[0];
            repeat (4) @(posedge pclk);
            go(kss_pkg::KSS_MODE_FREE);
            repeat (30) @(posedge pclk);
            apb(1'b0, kss_pkg::KSS_STAT_ADDR, 32'h0);
            `CHK("refused busy", 2'b00, rd[4:3])
            `CHK("refused exposures", 0, n_exp)
        end
        opt_installed <= 1'b1;
        sensor_interline <= 1'b0;
        repeat (4) @(posedge pclk);
        // Reserved mode code, then abort from the armed state
        apb(1'b1, kss_pkg::KSS_CTRL_ADDR, 32'h31);
        apb(1'b0, kss_pkg::KSS_STAT_ADDR, 32'h0);
        `CHK("mode 3 refused", 2'b00, rd[4:3])
        go(kss_pkg::KSS_MODE_SERIES);
        apb(1'b1, kss_pkg::KSS_CTRL_ADDR, 32'h2);
        apb(1'b0, kss_pkg::KSS_STAT_ADDR, 32'h0);
        `CHK("abort idle", kss_pkg::KSS_IDLE, rd[14:8])
        for (int r = 0; r < 3; r++) begin
            for (int m = 0; m < 3; m++) begin
                // Full-height window and a non-dividing one as corners
                win = (r == 0) ? 12'h200 : (r == 2) ? 12'h0aa : 12'h040 << ($urandom % 3);
                expo = 2 + $urandom % 8;
                rowt = 1 + $urandom % 3;
                lag = 4'($urandom % 8);
                apb(1'b1, kss_pkg::KSS_EXPO_ADDR, expo);
                apb(1'b1, kss_pkg::KSS_WIN_ADDR, 32'(win));
                apb(1'b1, kss_pkg::KSS_ROWT_ADDR, rowt);
                apb(1'b1, kss_pkg::KSS_COMP_ADDR, 1 + $urandom % 6);
                apb(1'b1, kss_pkg::KSS_RDT_ADDR, 16 + $urandom % 16);
                subs = sub_total(win);
                rchk("subframes", kss_pkg::KSS_CAP_ADDR, subs);
                n_exp = 0;
                n_ro = 0;
                if (m == 1) pulse(1'b0);
                repeat (20) @(posedge pclk);
                go(2'(m));
                if (m > 0) begin
                    apb(1'b0, kss_pkg::KSS_STAT_ADDR, 32'h0);
                    `CHK("index", 12'h000, rd[31:20])
                    `CHK("armed", kss_pkg::KSS_ARM, rd[14:8])
                    repeat (20) @(posedge pclk);
                    `CHK("no early exposure", 0, n_exp)
                end
                for (int s = 0; s < 32'(subs) && m > 0; s++) begin
                    pulse(1'b0);
                    repeat (lag + expo + rowt * win + 12) @(posedge pclk);
                    if (m == 2) `CHK("one per sync", s + 1, n_exp)
                    if (m == 1) break;
                end
                for (int i = 0; i < 40000 && readout_active !== 1'b1; i++) @(posedge pclk);
                if (m > 0) pulse(1'b1);
                for (int i = 0; i < 40000 && n_ro < 1; i++) @(posedge pclk);
                if (n_ro < 1) begin
                    miscompares++;
                    finish_test;
                end
                repeat (10) @(posedge pclk);
                `CHK("exposures", subs, 32'(n_exp))
                `CHK("readouts", 1, n_ro)
                if (m > 0) begin
                    apb(1'b0, kss_pkg::KSS_STAT_ADDR, 32'h0);
                    `CHK("ignored sync", 1'b1, rd[15])
                end
            end
        end
        finish_test;
    end
endmodule // test_kinetics_subframe_sequencer
